// ### rtl/drive_net_consts.svh
// Operation
// (R01) controller raises trigger after code and data; the model drives code, data and trigger on the same clock edge
// (R02) done flag rises when command completes
// (R03) response echoes processed command code
// (R04) result bit: 0 normal, 1 error
// (R05) read data returned little-endian
// (R06) sixteen input slots take programmable functions
// (R07) forward and reverse are run levels
// (R08) stop style: 0 instant, 1 decelerate
// (R09) brake release input holds or releases brake
// (R10) four select bits index sixteen entries
// (R11) general flags in, mirrored on outputs
// (R12) torque limit: 0 disabled, 1 enabled
// (R13) panel unlock: 0 restricted, 1 released
// (R14) duplicated function is active if any slot
// (R15) panel/torque unassigned read one, else all
// (R16) sixteen output slots take programmable functions
// (R17) echo outputs reproduce their input states
// (R18) alarm and warning outputs follow their state
// (R19) moving output high while motor operates
// (R20) torque limited and speed reached outputs
// (R21) busy high during internal processing
// (R22) overload output is normally closed
// (R23) main power and direction outputs
// (R24) trigger low clears done flag
`ifndef DRIVE_NET_CONSTS_SVH
`define DRIVE_NET_CONSTS_SVH

// ----------------------------------------
// slot function codes
// ----------------------------------------
`define FN_NONE      6'h00
`define FN_FORWARD   6'h01
`define FN_REVERSE   6'h02
`define FN_STOP      6'h03
`define FN_BRAKE     6'h04
`define FN_PANEL     6'h05
`define FN_TLIM      6'h06
`define FN_SEL0      6'h08
`define FN_SEL1      6'h09
`define FN_SEL2      6'h0A
`define FN_SEL3      6'h0B
`define FN_ALARM     6'h10
`define FN_WARN      6'h11
`define FN_MOVING    6'h12
`define FN_TQ_AT_LIM 6'h13
`define FN_SPEED_OK  6'h14
`define FN_BUSY      6'h15
`define FN_OVERLOAD  6'h16
`define FN_MAIN_PWR  6'h17
`define FN_DIR       6'h18
`define FN_GEN0      6'h20
`define FN_GEN_LAST  6'h2F

// ----------------------------------------
// slot reset maps, slot 15 leftmost
// ----------------------------------------
`define IN_FN_RESET  {{9{6'h00}}, 6'h04, 6'h03, 6'h02, 6'h01, 6'h0A, 6'h09, 6'h08}
`define OUT_FN_RESET {6'h13, 6'h14, 6'h12, 6'h16, 6'h00, 6'h00, 6'h00, 6'h15, \
                      6'h10, 6'h11, 6'h03, 6'h02, 6'h01, 6'h0A, 6'h09, 6'h08}

// ----------------------------------------
// command codes: upper ten bits, low four pick a slot or entry
// ----------------------------------------
`define CMD_IN_FN_RD  10'h010
`define CMD_IN_FN_WR  10'h110
`define CMD_OUT_FN_RD 10'h011
`define CMD_OUT_FN_WR 10'h111
`define CMD_OPD_RD    10'h020
`define CMD_OPD_WR    10'h120
`define CMD_MON_IO    10'h205

`endif

// ### rtl/drive_net_pkg.sv
package drive_net_pkg;

    // slot function code
    typedef logic [5:0] slot_fn_type;

    // command handshake sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DONE
    } cmd_state_type;

    // decoded command kind
    typedef enum logic [2:0] {
        K_IN_RD,
        K_IN_WR,
        K_OUT_RD,
        K_OUT_WR,
        K_OPD_RD,
        K_OPD_WR,
        K_MON,
        K_BAD
    } cmd_kind_type;

endpackage

// ### rtl/input_fn_decode.sv
`timescale 1ns/1ps
`include "drive_net_consts.svh"

module input_fn_decode
(
    // slot levels and their function codes
    input  wire logic                          [15:0] i_slots,
    input  wire drive_net_pkg::slot_fn_type    [15:0] i_fn,
    // per-function results
    output logic                               [63:0] o_any,
    output logic                               [63:0] o_all
);
    import drive_net_pkg::*;

    // ----------------------------------------
    // or-combine and and-combine per function
    // ----------------------------------------
    always_comb
    begin
        o_any = '0;
        o_all = '1;  // unassigned reads as one
        for (int s = 0; s < 16; s++)
        begin
            if (i_slots[s])
            begin
                o_any[i_fn[s]] = 1'b1;  // see (R14)
            end
            else
            begin
                o_all[i_fn[s]] = 1'b0;  // see (R15)
            end
        end
    end

endmodule // input_fn_decode

// ### rtl/op_data_mem.sv
`timescale 1ns/1ps

module op_data_mem
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_resetn,
    // write port
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
    input  wire logic [WIDTH-1:0]         i_wr_data,
    // two registered read ports
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr_a,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr_b,
    output logic      [WIDTH-1:0]         o_rd_data_a,
    output logic      [WIDTH-1:0]         o_rd_data_b
);

    // storage has no reset; entries start unknown until written
    logic [WIDTH-1:0] mem_q [DEPTH];

    // ----------------------------------------
    // write
    // ----------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_wr_en)
        begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    // ----------------------------------------
    // registered reads
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_rd_data_a <= '0;
            o_rd_data_b <= '0;
        end
        else
        begin
            o_rd_data_a <= mem_q[i_rd_addr_a];
            o_rd_data_b <= mem_q[i_rd_addr_b];
        end
    end

endmodule // op_data_mem

// ### rtl/drive_net_io.sv
`timescale 1ns/1ps
`include "drive_net_consts.svh"

module drive_net_io
#(
    parameter int CODE_W = 14,
    parameter int DATA_W = 32
)
(
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_resetn,
    // remote register command
    input  wire logic [CODE_W-1:0]          i_cmd_code,
    input  wire logic                       i_command_trigger,
    input  wire logic [DATA_W-1:0]          i_wr_data,
    // remote register response
    output logic      [CODE_W-1:0]          o_resp_code,
    output logic                            o_command_done_flag,
    output logic                            o_resp_status,
    output logic      [DATA_W-1:0]          o_rd_data,
    // remote i/o words
    input  wire logic [15:0]                i_remote_input_slots,
    output logic      [15:0]                o_remote_output_slots,
    // motor state from the drive core
    input  wire logic                       i_alarm,
    input  wire logic                       i_warning,
    input  wire logic                       i_motor_moving,
    input  wire logic                       i_torque_at_limit,
    input  wire logic                       i_speed_reached,
    input  wire logic                       i_overload,
    input  wire logic                       i_main_power_on,
    input  wire logic                       i_dir_forward,
    // controls to the drive core
    output logic                            o_forward_run,
    output logic                            o_reverse_run,
    output logic                            o_decel_stop,
    output logic                            o_brake_release,
    output logic                            o_panel_unlock,
    output logic                            o_torque_limit_enable,
    output logic      [3:0]                 o_op_data_index,
    output logic      [DATA_W-1:0]          o_op_data_value,
    output logic      [15:0]                o_general_flags
);
    import drive_net_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------

    // classify a command code
    function automatic cmd_kind_type kind_of(input logic [CODE_W-1:0] code);
        logic [9:0] hi;
        hi = code[13:4];
        unique case (hi)
            `CMD_IN_FN_RD:  kind_of = K_IN_RD;
            `CMD_IN_FN_WR:  kind_of = K_IN_WR;
            `CMD_OUT_FN_RD: kind_of = K_OUT_RD;
            `CMD_OUT_FN_WR: kind_of = K_OUT_WR;
            `CMD_OPD_RD:    kind_of = K_OPD_RD;
            `CMD_OPD_WR:    kind_of = K_OPD_WR;
            `CMD_MON_IO:    kind_of = K_MON;
            default:        kind_of = K_BAD;
        endcase
    endfunction

    // a function code that the slots may take
    function automatic logic fn_legal(input slot_fn_type fn);
        fn_legal = (fn <= `FN_DIR) || (fn >= `FN_GEN0 && fn <= `FN_GEN_LAST);
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    slot_fn_type   [15:0]     in_fn_q;     // input slot assignment
    slot_fn_type   [15:0]     out_fn_q;    // output slot assignment
    cmd_state_type            state_q;     // handshake sequencer
    logic                     trigger_q;   // trigger last cycle
    logic                     busy_q;      // internal processing
    logic          [CODE_W-1:0] code_q;    // latched command code
    cmd_kind_type             kind_q;      // latched command kind
    logic                     err_q;       // latched result
    logic          [DATA_W-1:0] data_q;    // latched read data

    // ----------------------------------------
    // input slot decode
    // ----------------------------------------
    logic [63:0] fn_any;   // any assigned slot active
    logic [63:0] fn_all;   // all assigned slots active

    input_fn_decode u_decode
    (
        .i_slots (i_remote_input_slots),
        .i_fn    (in_fn_q),
        .o_any   (fn_any),
        .o_all   (fn_all)
    );

    // four select bits form a binary entry number
    wire [3:0] sel_idx = {fn_any[`FN_SEL3], fn_any[`FN_SEL2],
                          fn_any[`FN_SEL1], fn_any[`FN_SEL0]};  // see (R10)

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire          trigger_rise = i_command_trigger & ~trigger_q;  // see (R01)
    wire          start     = trigger_rise && (state_q == ST_IDLE);
    cmd_kind_type cmd_kind;
    assign cmd_kind = kind_of(i_cmd_code);
    wire  [3:0]   cmd_idx   = i_cmd_code[3:0];
    wire  slot_fn_type wr_fn = slot_fn_type'(i_wr_data[5:0]);
    wire          fn_ok     = fn_legal(wr_fn) && (i_wr_data[DATA_W-1:6] == '0);
    wire          in_wr     = start && cmd_kind == K_IN_WR && fn_ok;
    wire          out_wr    = start && cmd_kind == K_OUT_WR && fn_ok;
    wire          opd_wr    = start && cmd_kind == K_OPD_WR;
    wire          start_err = (cmd_kind == K_BAD) ||
                              ((cmd_kind == K_IN_WR || cmd_kind == K_OUT_WR) && !fn_ok);

    // ----------------------------------------
    // operation data store
    // ----------------------------------------
    logic [DATA_W-1:0] opd_cmd_rd;  // entry read for a command
    logic [DATA_W-1:0] opd_sel_rd;  // entry picked by the select bits

    op_data_mem #(.WIDTH(DATA_W), .DEPTH(16)) u_mem
    (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_wr_en     (opd_wr),
        .i_wr_addr   (cmd_idx),
        .i_wr_data   (i_wr_data),
        .i_rd_addr_a (cmd_idx),
        .i_rd_addr_b (sel_idx),
        .o_rd_data_a (opd_cmd_rd),
        .o_rd_data_b (opd_sel_rd)
    );

    // ----------------------------------------
    // response data selection
    // ----------------------------------------
    // value bit 0 is the low bit of byte 0, the first byte sent
    logic [DATA_W-1:0] resp_d;
    always_comb
    begin
        unique case (kind_q)
            K_IN_RD:  resp_d = DATA_W'(in_fn_q[code_q[3:0]]);
            K_OUT_RD: resp_d = DATA_W'(out_fn_q[code_q[3:0]]);
            K_OPD_RD: resp_d = opd_cmd_rd;                       // see (R05)
            K_MON:    resp_d = DATA_W'({o_remote_output_slots, i_remote_input_slots});
            default:  resp_d = '0;
        endcase
    end

    // ----------------------------------------
    // handshake sequencer
    // ----------------------------------------
    cmd_state_type state_d;
    always_comb
    begin
        unique case (state_q)
            ST_IDLE: state_d = start ? ST_EXEC : ST_IDLE;
            ST_EXEC: state_d = ST_DONE;
            ST_DONE: state_d = i_command_trigger ? ST_DONE : ST_IDLE;  // see (R24)
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q <= ST_IDLE;
            trigger_q <= 1'b0;
            busy_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            trigger_q <= i_command_trigger;
            busy_q  <= (state_d == ST_EXEC);  // see (R21)
        end
    end

    // latch the command on the trigger edge
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            code_q <= '0;
            kind_q <= K_BAD;
            err_q  <= 1'b0;
        end
        else if (start)
        begin
            code_q <= i_cmd_code;
            kind_q <= cmd_kind;
            err_q  <= start_err;
        end
    end

    // capture the answer at the end of execution
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_resp_code         <= '0;
            o_resp_status       <= 1'b0;
            data_q              <= '0;
            o_command_done_flag <= 1'b0;
        end
        else if (state_q == ST_EXEC)
        begin
            o_resp_code         <= code_q;   // see (R03)
            o_resp_status       <= err_q;    // see (R04)
            data_q              <= resp_d;   // see (R05)
            o_command_done_flag <= 1'b1;     // see (R02)
        end
        else if (state_q == ST_DONE && !i_command_trigger)
        begin
            o_command_done_flag <= 1'b0;     // see (R24)
        end
    end
    assign o_rd_data = data_q;

    // ----------------------------------------
    // slot assignment tables
    // ----------------------------------------
    // a bad code is refused whole, but unused codes 07h and 0Ch-0Fh pass fn_legal and can still be stored in a slot
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            in_fn_q  <= `IN_FN_RESET;    // see (R06)
            out_fn_q <= `OUT_FN_RESET;   // see (R16)
        end
        else
        begin
            if (in_wr)
                in_fn_q[cmd_idx] <= wr_fn;    // see (R06)
            if (out_wr)
                out_fn_q[cmd_idx] <= wr_fn;   // see (R16)
        end
    end

    // ----------------------------------------
    // output slot sources
    // ----------------------------------------
    logic [63:0] out_src;
    always_comb
    begin
        out_src                  = '0;
        out_src[`FN_FORWARD]     = fn_any[`FN_FORWARD];  // see (R17)
        out_src[`FN_REVERSE]     = fn_any[`FN_REVERSE];
        out_src[`FN_STOP]        = fn_any[`FN_STOP];
        out_src[`FN_BRAKE]       = fn_any[`FN_BRAKE];
        out_src[`FN_PANEL]       = fn_all[`FN_PANEL];
        out_src[`FN_TLIM]        = fn_all[`FN_TLIM];
        out_src[`FN_SEL0]        = fn_any[`FN_SEL0];
        out_src[`FN_SEL1]        = fn_any[`FN_SEL1];
        out_src[`FN_SEL2]        = fn_any[`FN_SEL2];
        out_src[`FN_SEL3]        = fn_any[`FN_SEL3];
        out_src[`FN_ALARM]       = i_alarm;              // see (R18)
        out_src[`FN_WARN]        = i_warning;            // see (R18)
        out_src[`FN_MOVING]      = i_motor_moving;       // see (R19)
        out_src[`FN_TQ_AT_LIM]   = i_torque_at_limit;    // see (R20)
        out_src[`FN_SPEED_OK]    = i_speed_reached;      // see (R20)
        out_src[`FN_BUSY]        = busy_q;               // see (R21)
        out_src[`FN_OVERLOAD]    = ~i_overload;          // see (R22)
        out_src[`FN_MAIN_PWR]    = i_main_power_on;      // see (R23)
        out_src[`FN_DIR]         = i_dir_forward;        // see (R23)
        out_src[`FN_GEN_LAST:`FN_GEN0] = fn_any[`FN_GEN_LAST:`FN_GEN0];  // see (R11)
    end

    logic [15:0] out_word_d;
    always_comb
    begin
        for (int s = 0; s < 16; s++)
            out_word_d[s] = out_src[out_fn_q[s]];        // see (R16)
    end

    // ----------------------------------------
    // registered outputs to the network and the core
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_remote_output_slots <= '0;
            o_forward_run         <= 1'b0;
            o_reverse_run         <= 1'b0;
            o_decel_stop          <= 1'b0;
            o_brake_release       <= 1'b0;
            o_panel_unlock        <= 1'b0;
            o_torque_limit_enable <= 1'b0;
            o_op_data_index       <= '0;
            o_general_flags       <= '0;
        end
        else
        begin
            o_remote_output_slots <= out_word_d;
            o_forward_run         <= fn_any[`FN_FORWARD]; // see (R07)
            o_reverse_run         <= fn_any[`FN_REVERSE]; // see (R07)
            o_decel_stop          <= fn_any[`FN_STOP];    // see (R08)
            o_brake_release       <= fn_any[`FN_BRAKE];   // see (R09)
            o_panel_unlock        <= fn_all[`FN_PANEL];   // see (R13)
            o_torque_limit_enable <= fn_all[`FN_TLIM];    // see (R12)
            o_op_data_index       <= sel_idx;             // see (R10)
            o_general_flags       <= fn_any[`FN_GEN_LAST:`FN_GEN0]; // see (R11)
        end
    end
    // entry value arrives in the same cycle as the index, from the memory register
    assign o_op_data_value = opd_sel_rd;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    done_after_command_trigger_a: assert property (start |-> !o_command_done_flag ##2 o_command_done_flag) // see (R02)
        else $error("done flag not raised two cycles after trigger");

    done_clear_a: assert property (o_command_done_flag && state_q == ST_DONE && !i_command_trigger
                                   |=> !o_command_done_flag) // see (R24)
        else $error("done flag not cleared after trigger fell");

    code_echo_a: assert property (start |-> ##2 o_resp_code == $past(i_cmd_code, 2)) // see (R03)
        else $error("echoed code differs from command");

    bad_status_a: assert property (start && cmd_kind == K_BAD |-> ##2 o_resp_status) // see (R04)
        else $error("unknown command not flagged as error");

    busy_window_a: assert property (start |=> busy_q ##1 !busy_q && o_command_done_flag) // see (R21)
        else $error("busy does not span execution");

    run_level_a: assert property (in_fn_q[3] == `FN_FORWARD && i_remote_input_slots[3]
                                  |=> o_forward_run) // see (R07)
        else $error("forward run not raised by its slot");

    panel_free_a: assert property (!(in_fn_q[0] == `FN_PANEL || in_fn_q[1] == `FN_PANEL ||
                                     in_fn_q[2] == `FN_PANEL || in_fn_q[3] == `FN_PANEL ||
                                     in_fn_q[4] == `FN_PANEL || in_fn_q[5] == `FN_PANEL ||
                                     in_fn_q[6] == `FN_PANEL || in_fn_q[7] == `FN_PANEL ||
                                     in_fn_q[8] == `FN_PANEL || in_fn_q[9] == `FN_PANEL ||
                                     in_fn_q[10] == `FN_PANEL || in_fn_q[11] == `FN_PANEL ||
                                     in_fn_q[12] == `FN_PANEL || in_fn_q[13] == `FN_PANEL ||
                                     in_fn_q[14] == `FN_PANEL || in_fn_q[15] == `FN_PANEL)
                                   |=> o_panel_unlock) // see (R15)
        else $error("unassigned panel unlock not read as one");

    alarm_slot_a: assert property (out_fn_q[7] == `FN_ALARM
                                   |=> o_remote_output_slots[7] == $past(i_alarm)) // see (R18)
        else $error("alarm slot does not follow alarm");

    overload_nc_a: assert property (out_fn_q[12] == `FN_OVERLOAD
                                    |=> o_remote_output_slots[12] != $past(i_overload)) // see (R22)
        else $error("overload slot is not normally closed");

    cmd_write_c: cover property (start && cmd_kind == K_OPD_WR ##2 o_command_done_flag);
    cmd_read_c:  cover property (start && cmd_kind == K_OPD_RD ##2 o_command_done_flag);
    handshake_c: cover property (o_command_done_flag ##1 !o_command_done_flag);
    run_forward_c: cover property (o_forward_run && o_decel_stop);

endmodule // drive_net_io

// ### sim/net_ctrl_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// controller model: one command handshake at a time
// ----------------------------------------
module net_ctrl_model
(
    // clock
    input  wire logic        i_clk,
    // response from the drive
    input  wire logic        i_done,
    // command to the drive
    output logic      [13:0] o_code,
    output logic             o_trigger,
    output logic      [31:0] o_data
);
    initial
    begin
        o_code = 14'h0000;
        o_data = 32'h00000000;
        o_trigger = 1'b0;
    end

    // raise trigger, wait done, drop trigger, wait clear; waits are bounded
    task automatic run_cmd(input logic [13:0] c, input logic [31:0] d, output int lat);
        int n;
        @(posedge i_clk);
        o_code <= c;
        o_data <= d;
        o_trigger <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (i_done !== 1'b1 && n < 20);
        lat = n;
        o_trigger <= 1'b0;
        n = 0;
        while (i_done !== 1'b0 && n < 20)
        begin
            @(posedge i_clk);
            n++;
        end
        // released lines carry the inverse so a stale value cannot pass
        o_code <= ~c;
        o_data <= ~d;
    endtask
endmodule // net_ctrl_model

// ### sim/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import drive_net_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk, rstn, trigger, done, stat, fw_run, rv_run, dec, brk, pnl, tle;
    logic [13:0] code, rcode;
    logic [31:0] wd, rd, opv;
    logic [15:0] inw, outw, gen;
    logic [7:0]  st;   // dir, power, overload, speed, torque, moving, warn, alarm
    logic [3:0]  idx;
    int          mismatches = 0, n_tests = 0, cyc = 0, lat;
    logic [15:0] ob [8] = '{16'h1080, 16'h1040, 16'h3000, 16'h9000,
                            16'h5000, 16'h0000, 16'h1000, 16'h1000};
    logic [13:0] rmc [8] = '{14'h1108, 14'h1109, 14'h110A, 14'h110B,
                             14'h110C, 14'h1119, 14'h111A, 14'h111B};
    logic [5:0]  rmf [8] = '{6'h01, 6'h05, 6'h05, 6'h23, 6'h06, 6'h23, 6'h17, 6'h18};

    drive_net_io DUT (.i_clk(clk), .i_resetn(rstn), .i_cmd_code(code),
        .i_command_trigger(trigger), .i_wr_data(wd), .o_resp_code(rcode),
        .o_command_done_flag(done), .o_resp_status(stat), .o_rd_data(rd),
        .i_remote_input_slots(inw), .o_remote_output_slots(outw), .i_alarm(st[0]),
        .i_warning(st[1]), .i_motor_moving(st[2]), .i_torque_at_limit(st[3]),
        .i_speed_reached(st[4]), .i_overload(st[5]), .i_main_power_on(st[6]),
        .i_dir_forward(st[7]), .o_forward_run(fw_run), .o_reverse_run(rv_run),
        .o_decel_stop(dec), .o_brake_release(brk), .o_panel_unlock(pnl),
        .o_torque_limit_enable(tle), .o_op_data_index(idx), .o_op_data_value(opv),
        .o_general_flags(gen));
    net_ctrl_model u_ctrl (.i_clk(clk), .i_done(done), .o_code(code), .o_trigger(trigger),
        .o_data(wd));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // levels and value memory both settle one cycle later
    task automatic io(input logic [15:0] w, input logic [7:0] s);
        @(posedge clk);
        inw <= w;
        st  <= s;
        repeat (3) @(posedge clk);
    endtask

    task automatic cmd(input logic [13:0] c, input logic [31:0] d);
        u_ctrl.run_cmd(c, d, lat);
        check(lat, 3);
        check(rcode, c);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_opdata;
        cmd({10'h120, 4'h5}, 32'h11223344);
        check(stat, 1'b0);
        cmd({10'h020, 4'h5}, 32'h00000000);
        check(rd, 32'h11223344);
        io(16'h0005, 8'h00);
        check(idx, 4'h5);
        check(opv, 32'h11223344);
    endtask

    task automatic t_bad;
        cmd({10'h3FF, 4'h0}, 32'h00000001);
        check(stat, 1'b1);
        check(rd, 32'h00000000);
        cmd({10'h110, 4'h8}, 32'h00000019);
        check(stat, 1'b1);
    endtask

    task automatic t_inmap;
        io(16'h0000, 8'h00);
        check({pnl, tle}, 2'b11);
        for (int i = 0; i < 7; i++)
        begin
            io(16'h0001 << i, 8'h00);
            check({brk, dec, rv_run, fw_run, idx[2:0]}, 32'h1 << i);
            check(outw, 16'h1000 | ((16'h0001 << i) & 16'h003F));
        end
    endtask

    task automatic t_status;
        for (int i = 0; i < 8; i++)
        begin
            io(16'h0000, 8'h01 << i);
            check(outw, ob[i]);
        end
    endtask

    // remap: duplicate run, paired unlock, a general flag, torque limit, outputs
    task automatic t_remap;
        for (int i = 0; i < 8; i++)
        begin
            cmd(rmc[i], {26'h0, rmf[i]});
            check(stat, 1'b0);
        end
        cmd({10'h010, 4'h9}, 32'h00000000);
        check(rd, 32'h00000005);
        io(16'h0100, 8'h00);
        check({fw_run, pnl, tle}, 3'b100);
        io(16'h0200, 8'h00);
        check(pnl, 1'b0);
        io(16'h1600, 8'hC0);
        check({pnl, tle}, 2'b11);
        check(outw[11:10], 2'b11);
        io(16'h0800, 8'h00);
        check({gen, outw[9]}, {16'h0008, 1'b1});
        cmd({10'h011, 4'hA}, 32'h00000000);
        check(rd, 32'h00000017);
        cmd({10'h205, 4'h0}, 32'h00000000);
        check(rd, 32'h12000800);
    endtask

    // ----------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // a hang is cut short well past the roughly 180 cycles needed
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            mismatches++;
            results;
        end
    end

    initial
    begin
        rstn = 1'b0;
        inw  = 16'h0000;
        st   = 8'h00;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        check(done, 1'b0);
        t_opdata;
        t_bad;
        t_inmap;
        t_status;
        t_remap;
        results;
    end
endmodule // tb_top
